/* dv/rbp_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rbp_mem_model (
  // clock and stall length
  input wire logic clk,
  input wire logic [3:0] stall,
  // bus from the port
  input wire logic [15:0] addr,
  input wire logic [7:0] dout,
  input wire logic doe,
  input wire logic rd_n,
  input wire logic rd_oe,
  input wire logic wr_n,
  input wire logic wr_oe,
  // answers
  output logic [7:0] din,
  output logic wait_n
);
  logic [7:0] mem [256];
  logic [7:0] last = 8'h00;
  logic [3:0] cnt = 4'h0;
  logic rd_act;
  logic act;
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h5a;
    end
  end
  assign rd_act = rd_oe && !rd_n;
  assign act = rd_act || (wr_oe && !wr_n);
  assign wait_n = !(act && (cnt < stall));
  // shared data wire
  // a released bus toggles every cycle so a stale value never looks valid
  assign din = doe ? dout : (rd_act ? mem[addr[7:0]] : ~last);
  always @(posedge clk) begin
    cnt <= act ? cnt + 4'h1 : 4'h0;
    last <= din;
    if (wr_oe && !wr_n && doe) begin
      mem[addr[7:0]] <= dout;
    end
  end
endmodule : rbp_mem_model
`default_nettype wire

/* dv/romless_mcu_external_bus_port_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module romless_mcu_external_bus_port_bench
  import rbp_pkg::*;
();
  typedef struct packed {
    rbp_kind_e k;
    logic [15:0] a;
    logic [15:0] bc;
    logic [7:0] wd;
    logic [3:0] nw;
    logic [3:0] fl;
    logic [7:0] d;
  } rbp_row_s;
  logic clk = 1'b0, srst = 1'b1, ce = 1'b1, req_valid = 1'b0, halt = 1'b0, hold_req = 1'b0;
  rbp_kind_e req_kind = K_FETCH;
  logic [15:0] req_addr = 16'h0000, req_bc = 16'h0000;
  logic [7:0] req_wdata = 8'h00, ser_load_data = 8'h00, port_dir = 8'h00, port_out = 8'h00;
  logic [7:0] pin_ext = 8'h00, sin = 8'h3c, sout = 8'ha5;
  logic level_irq_input = 1'b0, rising_irq_input = 1'b0, programmable_edge_irq_input = 1'b0;
  logic irq_enable = 1'b0, edge_polarity_select = 1'b0, serial_clk = 1'b1, serial_in = 1'b0;
  logic ser_load = 1'b0, done_seen = 1'b0;
  logic [1:0] irq_clear = 2'h0;
  logic [3:0] stall = 4'h0;
  logic req_ready, rsp_done, hold_grant, address_lines_oe, data_lines_oe, read_strobe_n_o;
  logic read_strobe_n_oe, write_strobe_n_o, write_strobe_n_oe, wait_n, opcode_fetch_flag;
  logic far_memory_flag_n, port_cycle_pulse, serial_out, ser_done;
  logic [15:0] address_lines_o;
  logic [7:0] rsp_rdata, data_lines_i, data_lines_o, ser_rx_data, bidir_port_i, bidir_port_o;
  logic [7:0] bidir_port_oe, port_in;
  logic [2:0] irq_pending;
  int bad_count = 0, n_checks = 0, cyc = 0;
  // fl: address driven, far flag high throughout, fetch flag, port pulse
  rbp_row_s rows [12] = '{
    '{K_FETCH, 16'h0010, 16'h0000, 8'h00, 4'h0, 4'b1110, 8'h4a},
    '{K_MEM_RD, 16'h0fff, 16'h0000, 8'h00, 4'h1, 4'b1100, 8'ha5},
    '{K_MEM_RD, 16'h1000, 16'h0000, 8'h00, 4'h0, 4'b0000, 8'h00},
    '{K_MEM_RD, 16'hff7f, 16'h0000, 8'h00, 4'h0, 4'b0000, 8'h00},
    '{K_MEM_RD, 16'hff80, 16'h0000, 8'h00, 4'h0, 4'b0100, 8'h00},
    '{K_MEM_WR, 16'h0abc, 16'h0000, 8'hc3, 4'h2, 4'b1100, 8'hc3},
    '{K_MEM_RD, 16'h0abc, 16'h0000, 8'h00, 4'h0, 4'b1100, 8'hc3},
    '{K_IO_WR, 16'h0042, 16'h0000, 8'h7e, 4'h0, 4'b1100, 8'h7e},
    '{K_IO_RD, 16'h0042, 16'h0000, 8'h00, 4'h3, 4'b1100, 8'h7e},
    '{K_PE_ONE, 16'h0000, 16'h1234, 8'h00, 4'h0, 4'b1101, 8'h01},
    '{K_PE_TWO, 16'h0000, 16'hbeef, 8'h00, 4'h0, 4'b1101, 8'h02},
    '{K_PE_FOUR, 16'h0000, 16'h5555, 8'h00, 4'h0, 4'b0101, 8'h04}
  };

  always #25 clk = ~clk;
  assign bidir_port_i = (bidir_port_oe & bidir_port_o) | (~bidir_port_oe & pin_ext);

  rbp_bus_port dut_u (
    .clk, .srst, .ce, .req_valid, .req_kind, .req_addr, .req_wdata, .req_bc, .req_ready,
    .rsp_done, .rsp_rdata, .halt, .hold_req, .hold_grant, .level_irq_input,
    .rising_irq_input, .programmable_edge_irq_input, .irq_enable, .edge_polarity_select,
    .irq_clear, .irq_pending, .address_lines_o, .address_lines_oe, .data_lines_i,
    .data_lines_o, .data_lines_oe, .read_strobe_n_o, .read_strobe_n_oe, .write_strobe_n_o,
    .write_strobe_n_oe, .wait_n, .opcode_fetch_flag, .far_memory_flag_n, .port_cycle_pulse,
    .serial_clk, .serial_in, .serial_out, .ser_load, .ser_load_data, .ser_rx_data, .ser_done,
    .bidir_port_i, .bidir_port_o, .bidir_port_oe, .port_dir, .port_out, .port_in
  );
  rbp_mem_model mem_u (
    .clk, .stall, .addr(address_lines_o), .dout(data_lines_o), .doe(data_lines_oe),
    .rd_n(read_strobe_n_o), .rd_oe(read_strobe_n_oe), .wr_n(write_strobe_n_o),
    .wr_oe(write_strobe_n_oe), .din(data_lines_i), .wait_n
  );

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_n(input int got, input int exp);
    n_checks++;
    if (got != exp) begin
      bad_count++;
      $display("BAD %0t count %0d expected %0d", $time, got, exp);
    end
  endtask : chk_n

  task automatic wt(input int k);
    repeat (k) @(posedge clk);
    @(negedge clk);
  endtask : wt

  task automatic chk_rst();
    chk({address_lines_oe, data_lines_oe, read_strobe_n_oe, write_strobe_n_oe,
         far_memory_flag_n, opcode_fetch_flag, port_cycle_pulse, hold_grant, serial_out,
         irq_pending}, 12'h088);
  endtask : chk_rst

  // one request, watched every cycle until the done pulse
  task automatic bus_cycle(input rbp_row_s r);
    logic [15:0] sa = 16'h0000;
    logic [7:0] sd = 8'h00;
    logic [3:0] fl = 4'b0100;
    int n = 0, nrd = 0, nwr = 0, nbad = 0;
    logic rd_k;
    logic wr_k;
    rd_k = r.k inside {K_FETCH, K_MEM_RD, K_IO_RD};
    wr_k = r.k inside {K_MEM_WR, K_IO_WR};
    @(posedge clk);
    req_valid <= 1'b1;
    req_kind <= r.k;
    req_addr <= r.a;
    req_bc <= r.bc;
    req_wdata <= r.wd;
    stall <= r.nw;
    @(posedge clk);
    req_valid <= 1'b0;
    while (n < 30) begin
      @(negedge clk);
      n++;
      if (rsp_done === 1'b1) break;
      fl = fl | {address_lines_oe, 1'b0, opcode_fetch_flag, port_cycle_pulse};
      fl[2] = fl[2] & far_memory_flag_n;
      if (address_lines_oe) sa = address_lines_o;
      if (data_lines_oe) sd = data_lines_o;
      // unknown strobes or enables must not count as a clean cycle
      nrd += int'(read_strobe_n_oe === 1'b1 && read_strobe_n_o === 1'b0);
      nwr += int'(write_strobe_n_oe === 1'b1 && write_strobe_n_o === 1'b0);
      nbad += int'((write_strobe_n_oe === 1'b1 && write_strobe_n_o === 1'b0 &&
                    data_lines_oe !== 1'b1) ||
                   (read_strobe_n_oe === 1'b1 && read_strobe_n_o === 1'b0 &&
                    data_lines_oe !== 1'b0));
    end
    chk_n(n, 4 + int'(r.nw));
    chk_n(nrd, rd_k ? 2 + int'(r.nw) : 0);
    chk_n(nwr, wr_k ? 2 + int'(r.nw) : 0);
    chk_n(nbad, 0);
    chk(fl, r.fl);
    if (r.fl[3]) chk(sa, (r.k inside {K_PE_ONE, K_PE_TWO}) ? r.bc : r.a);
    if (!rd_k) chk(sd, r.d);
    else if (r.fl[3]) chk(rsp_rdata, r.d);
  endtask : bus_cycle

  // a hang is cut short well beyond the expected few hundred cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (ser_done === 1'b1) done_seen <= 1'b1;
    if (cyc == 3000) begin
      bad_count++;
      test_done();
    end
  end

  initial begin
    int n;
    repeat (19) @(posedge clk);
    @(negedge clk);
    chk_rst();
    @(posedge clk);
    srst <= 1'b0;
    foreach (rows[i]) bus_cycle(rows[i]);
    @(posedge clk);
    hold_req <= 1'b1;
    wt(3);
    chk({hold_grant, address_lines_oe, data_lines_oe, read_strobe_n_oe, write_strobe_n_oe,
         req_ready}, 6'b100000);
    @(posedge clk);
    hold_req <= 1'b0;
    do begin
      @(negedge clk);
      n++;
    end while (read_strobe_n_oe !== 1'b1 && n < 20);
    chk_n(int'(n <= HOLD_REDRIVE_CYC + 1), 1);
    chk(hold_grant, 1'b0);
    @(posedge clk);
    halt <= 1'b1;
    wt(2);
    chk({req_ready, read_strobe_n_oe, write_strobe_n_oe}, 3'b000);
    // clock enable low must freeze the level request as well
    @(posedge clk);
    halt <= 1'b0;
    level_irq_input <= 1'b1;
    ce <= 1'b0;
    wt(2);
    chk(irq_pending[0], 1'b0);
    @(posedge clk);
    ce <= 1'b1;
    wt(2);
    chk(irq_pending[0], 1'b1);
    @(posedge clk);
    level_irq_input <= 1'b0;
    wt(2);
    chk(irq_pending[0], 1'b0);
    for (int e = 0; e < 2; e++) begin
      @(posedge clk);
      irq_enable <= e[0];
      rising_irq_input <= 1'b1;
      wt(3);
      chk(irq_pending[1], e[0]);
      @(posedge clk);
      rising_irq_input <= 1'b0;
      irq_clear <= 2'b01;
      wt(2);
      chk(irq_pending[1], 1'b0);
      @(posedge clk);
      irq_clear <= 2'b00;
    end
    for (int p = 0; p < 2; p++) begin
      @(posedge clk);
      edge_polarity_select <= p[0];
      programmable_edge_irq_input <= p[0];
      irq_clear <= 2'b10;
      wt(3);
      @(posedge clk);
      irq_clear <= 2'b00;
      programmable_edge_irq_input <= !p[0];
      wt(3);
      chk(irq_pending[2], 1'b0);
      @(posedge clk);
      programmable_edge_irq_input <= p[0];
      wt(3);
      chk(irq_pending[2], 1'b1);
    end
    // serial clock idles high, so the first edge of a frame is a fall
    @(posedge clk);
    ser_load <= 1'b1;
    ser_load_data <= sout;
    @(posedge clk);
    ser_load <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk);
      serial_clk <= 1'b0;
      serial_in <= sin[i];
      wt(3);
      chk(serial_out, sout[i]);
      @(posedge clk);
      serial_clk <= 1'b1;
      wt(3);
    end
    chk({ser_rx_data, done_seen}, {sin, 1'b1});
    for (int d = 0; d < 2; d++) begin
      @(posedge clk);
      port_dir <= d[0] ? 8'hf0 : 8'h0f;
      port_out <= 8'ha5;
      pin_ext <= 8'h3c;
      wt(3);
      chk({bidir_port_oe, bidir_port_o, port_in}, d[0] ? 24'hf0a5ac : 24'h0fa535);
    end
    // reset lands in the middle of a write
    @(posedge clk);
    req_valid <= 1'b1;
    req_kind <= K_MEM_WR;
    req_addr <= 16'h0077;
    req_wdata <= 8'h99;
    @(posedge clk);
    req_valid <= 1'b0;
    @(posedge clk);
    srst <= 1'b1;
    wt(1);
    chk_rst();
    @(posedge clk);
    srst <= 1'b0;
    bus_cycle(rows[1]);
    test_done();
  end
endmodule : romless_mcu_external_bus_port_bench
`default_nettype wire

/* hw/rbp_bus_port.sv */
`timescale 1ns/1ps
`default_nettype none
module rbp_bus_port
  import rbp_pkg::*;
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // core request side
  input wire logic req_valid,
  input wire rbp_kind_e req_kind,
  input wire logic [15:0] req_addr,
  input wire logic [7:0] req_wdata,
  input wire logic [15:0] req_bc,
  output logic req_ready,
  output logic rsp_done,
  output logic [7:0] rsp_rdata,
  // core state
  input wire logic halt,
  input wire logic hold_req,
  output logic hold_grant,
  // interrupts
  input wire logic level_irq_input,
  input wire logic rising_irq_input,
  input wire logic programmable_edge_irq_input,
  input wire logic irq_enable,
  input wire logic edge_polarity_select,
  input wire logic [1:0] irq_clear,
  output logic [2:0] irq_pending,
  // external bus
  output logic [15:0] address_lines_o,
  output logic address_lines_oe,
  input wire logic [7:0] data_lines_i,
  output logic [7:0] data_lines_o,
  output logic data_lines_oe,
  output logic read_strobe_n_o,
  output logic read_strobe_n_oe,
  output logic write_strobe_n_o,
  output logic write_strobe_n_oe,
  input wire logic wait_n,
  output logic opcode_fetch_flag,
  output logic far_memory_flag_n,
  output logic port_cycle_pulse,
  // serial port
  input wire logic serial_clk,
  input wire logic serial_in,
  output logic serial_out,
  input wire logic ser_load,
  input wire logic [7:0] ser_load_data,
  output logic [7:0] ser_rx_data,
  output logic ser_done,
  // bidirectional port
  input wire logic [7:0] bidir_port_i,
  output logic [7:0] bidir_port_o,
  output logic [7:0] bidir_port_oe,
  input wire logic [7:0] port_dir,
  input wire logic [7:0] port_out,
  output logic [7:0] port_in
);
  localparam int HOLD_CHK = HOLD_REDRIVE_CYC;

  function automatic logic is_read(input rbp_kind_e k);
    return (k == K_FETCH) || (k == K_MEM_RD) || (k == K_IO_RD);
  endfunction : is_read

  function automatic logic is_pe(input rbp_kind_e k);
    return (k == K_PE_ONE) || (k == K_PE_TWO) || (k == K_PE_FOUR);
  endfunction : is_pe

  function automatic logic is_mem(input rbp_kind_e k);
    return (k == K_FETCH) || (k == K_MEM_RD) || (k == K_MEM_WR);
  endfunction : is_mem

  // ---------------- bus cycle machine
  rbp_state_e state_r, state_nxt;
  rbp_kind_e kind_r, kind_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic [7:0] wdata_r, wdata_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic done_r, done_nxt;
  logic aoe_r, aoe_nxt;
  logic doe_r, doe_nxt;
  logic rd_r, rd_nxt;
  logic wr_r, wr_nxt;
  logic soe_r, soe_nxt;
  logic fetch_r, fetch_nxt;
  logic far_r, far_nxt;
  logic pcp_r, pcp_nxt;
  logic hold_r, hold_nxt;
  logic in_cyc;
  logic strobe_ph;

  // hold takes effect only between cycles, so a granted bus is idle; halt blocks new cycles but floats the strobes at once
  assign req_ready = (state_r == ST_IDLE) && !hold_r && !hold_req && !halt;

  always_comb begin
    state_nxt = state_r;
    kind_nxt = kind_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    rdata_nxt = rdata_r;
    done_nxt = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        if (req_valid && req_ready) begin
          state_nxt = ST_T1;
          kind_nxt = req_kind;
          addr_nxt = req_addr;
          wdata_nxt = req_wdata;
          unique case (req_kind)
            // [R13] B,C on address, code one
            K_PE_ONE: begin
              addr_nxt = req_bc;
              wdata_nxt = PE_CODE_ONE;
            end
            // [R14] B,C on address, code two
            K_PE_TWO: begin
              addr_nxt = req_bc;
              wdata_nxt = PE_CODE_TWO;
            end
            // [R15] code four, address floated below
            K_PE_FOUR: wdata_nxt = PE_CODE_FOUR;
            default: ;
          endcase
        end
      end
      ST_T1: state_nxt = ST_T2;
      // [R7] wait sampled at end of T2
      ST_T2: state_nxt = wait_n ? ST_T3 : ST_TW;
      // [R7] stretch while wait held low
      ST_TW: begin
        if (wait_n) begin
          state_nxt = ST_T3;
        end
      end
      ST_T3: begin
        state_nxt = ST_IDLE;
        done_nxt = 1'b1;
        // [R10] data gated in by the read strobe
        if (is_read(kind_r)) begin
          rdata_nxt = data_lines_i;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    in_cyc = (state_nxt != ST_IDLE);
    strobe_ph = (state_nxt == ST_T2) || (state_nxt == ST_TW) || (state_nxt == ST_T3);
    // [R20] grant only from an idle bus, dropped as soon as hold goes
    hold_nxt = hold_r ? hold_req : (hold_req && state_r == ST_IDLE);
    // [R2] address only below program limit, io and pe one/two always
    aoe_nxt = in_cyc && (is_mem(kind_nxt) ? (addr_nxt <= PROG_LAST) :
                         (kind_nxt != K_PE_FOUR));
    // [R3] device drives data for writes and emulation codes
    doe_nxt = in_cyc && !is_read(kind_nxt);
    // [R9] write strobe only while write data is valid
    wr_nxt = !(strobe_ph && (kind_nxt == K_MEM_WR || kind_nxt == K_IO_WR));
    rd_nxt = !(strobe_ph && is_read(kind_nxt));
    // [R9] [R10] strobes float in halt and hold
    soe_nxt = !(halt || hold_nxt);
    // [R8] fetch indicator for the whole fetch cycle
    fetch_nxt = in_cyc && (kind_nxt == K_FETCH);
    // [R1] far range flag, active low
    far_nxt = !(in_cyc && is_mem(kind_nxt) && addr_nxt >= FAR_FIRST && addr_nxt <= FAR_LAST);
    // [R16] [R19] strobe spans emulation cycle only
    pcp_nxt = in_cyc && is_pe(kind_nxt);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= ST_IDLE;
      kind_r <= K_FETCH;
      addr_r <= 16'h0000;
      wdata_r <= 8'h00;
      rdata_r <= 8'h00;
      done_r <= 1'b0;
      aoe_r <= 1'b0;
      doe_r <= 1'b0;
      rd_r <= 1'b1;
      wr_r <= 1'b1;
      soe_r <= 1'b0;
      fetch_r <= 1'b0;
      far_r <= 1'b1;
      pcp_r <= 1'b0;
      hold_r <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      kind_r <= kind_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      rdata_r <= rdata_nxt;
      done_r <= done_nxt;
      aoe_r <= aoe_nxt;
      doe_r <= doe_nxt;
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
      soe_r <= soe_nxt;
      fetch_r <= fetch_nxt;
      far_r <= far_nxt;
      pcp_r <= pcp_nxt;
      hold_r <= hold_nxt;
    end
  end

  assign address_lines_o = addr_r;
  assign address_lines_oe = aoe_r;
  assign data_lines_o = wdata_r;
  assign data_lines_oe = doe_r;
  assign read_strobe_n_o = rd_r;
  assign read_strobe_n_oe = soe_r;
  assign write_strobe_n_o = wr_r;
  assign write_strobe_n_oe = soe_r;
  assign opcode_fetch_flag = fetch_r;
  assign far_memory_flag_n = far_r;
  assign port_cycle_pulse = pcp_r;
  assign hold_grant = hold_r;
  assign rsp_done = done_r;
  assign rsp_rdata = rdata_r;

  // ---------------- interrupt inputs
  logic lvl_r, lvl_nxt;
  logic r1_prev_r, r1_prev_nxt;
  logic r2_prev_r, r2_prev_nxt;
  logic pend1_r, pend1_nxt;
  logic pend2_r, pend2_nxt;
  logic rise1;
  logic edge2;

  always_comb begin
    // [R4] level request follows the pin
    lvl_nxt = level_irq_input;
    r1_prev_nxt = rising_irq_input;
    r2_prev_nxt = programmable_edge_irq_input;
    rise1 = rising_irq_input && !r1_prev_r;
    // [R6] polarity picked by edge select
    edge2 = edge_polarity_select ? (programmable_edge_irq_input && !r2_prev_r) :
                                   (!programmable_edge_irq_input && r2_prev_r);
    // [R5] set beats clear, only when enabled
    pend1_nxt = (rise1 && irq_enable) || (pend1_r && !irq_clear[0]);
    pend2_nxt = edge2 || (pend2_r && !irq_clear[1]);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      lvl_r <= 1'b0;
      r1_prev_r <= 1'b0;
      r2_prev_r <= 1'b0;
      pend1_r <= 1'b0;
      pend2_r <= 1'b0;
    end else if (ce) begin
      lvl_r <= lvl_nxt;
      r1_prev_r <= r1_prev_nxt;
      r2_prev_r <= r2_prev_nxt;
      pend1_r <= pend1_nxt;
      pend2_r <= pend2_nxt;
    end
  end

  assign irq_pending = {pend2_r, pend1_r, lvl_r};

  // ---------------- serial clock edges and shifter
  logic sck_prev_r, sck_prev_nxt;
  rbp_ser_if sif ();

  always_comb begin
    sck_prev_nxt = serial_clk;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sck_prev_r <= 1'b1;
    end else if (ce) begin
      sck_prev_r <= sck_prev_nxt;
    end
  end

  assign sif.sck_rise = serial_clk && !sck_prev_r;
  assign sif.sck_fall = !serial_clk && sck_prev_r;
  assign sif.serial_in = serial_in;
  assign sif.load = ser_load;
  assign sif.load_data = ser_load_data;
  assign serial_out = sif.serial_out;
  assign ser_rx_data = sif.rx_data;
  assign ser_done = sif.done;

  rbp_serial u_serial (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .sif(sif)
  );

  // ---------------- bidirectional port
  logic [7:0] pin_r, pin_nxt;
  logic [7:0] pout_r, pout_nxt;
  logic [7:0] pdir_r, pdir_nxt;

  // [R18] each line steered by its own direction bit
  for (genvar i = 0; i < DATA_W; i++) begin : g_port
    always_comb begin
      pdir_nxt[i] = port_dir[i];
      pout_nxt[i] = port_out[i];
      pin_nxt[i] = port_dir[i] ? pout_r[i] : bidir_port_i[i];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pin_r <= 8'h00;
      pout_r <= 8'h00;
      pdir_r <= 8'h00;
    end else if (ce) begin
      pin_r <= pin_nxt;
      pout_r <= pout_nxt;
      pdir_r <= pdir_nxt;
    end
  end

  assign bidir_port_o = pout_r;
  assign bidir_port_oe = pdir_r;
  assign port_in = pin_r;

  // ---------------- checks
  chk_far_flag_range: assert property (@(posedge clk) disable iff (srst) // [R1]
    (state_r == ST_T1 && is_mem(kind_r)) |->
      (far_memory_flag_n == !(addr_r >= FAR_FIRST && addr_r <= FAR_LAST)))
    else $error("far memory flag wrong for address");
  chk_addr_drive_low: assert property (@(posedge clk) disable iff (srst) // [R2]
    (state_r == ST_T1 && is_mem(kind_r)) |-> (address_lines_oe == (addr_r <= PROG_LAST)))
    else $error("address enable wrong for memory cycle");
  chk_data_write_drive: assert property (@(posedge clk) disable iff (srst) // [R3]
    (!write_strobe_n_o) |-> data_lines_oe)
    else $error("write strobe without driven data");
  chk_level_irq_follow: assert property (@(posedge clk) disable iff (srst) // [R4]
    (ce && level_irq_input) |=> irq_pending[0])
    else $error("level interrupt not requested");
  chk_rise_irq_gate: assert property (@(posedge clk) disable iff (srst) // [R5]
    (ce && !pend1_r && !(rising_irq_input && !r1_prev_r && irq_enable)) |=> !pend1_r)
    else $error("rising interrupt pended without enabled edge");
  chk_edge_sel_fall: assert property (@(posedge clk) disable iff (srst) // [R6]
    (ce && !edge_polarity_select && r2_prev_r && !programmable_edge_irq_input) |=>
      pend2_r)
    else $error("selected falling edge missed");
  chk_wait_stretch: assert property (@(posedge clk) disable iff (srst) // [R7]
    (ce && (state_r == ST_T2 || state_r == ST_TW) && !wait_n) |=> state_r == ST_TW)
    else $error("wait not honoured");
  chk_fetch_flag_cycle: assert property (@(posedge clk) disable iff (srst) // [R8]
    (state_r != ST_IDLE) |-> (opcode_fetch_flag == (kind_r == K_FETCH)))
    else $error("fetch flag mismatch");
  chk_wr_float_hold: assert property (@(posedge clk) disable iff (srst) // [R9]
    hold_grant |-> (!write_strobe_n_oe && !read_strobe_n_oe))
    else $error("strobes driven during hold");
  chk_rd_strobe_phase: assert property (@(posedge clk) disable iff (srst) // [R10]
    (!read_strobe_n_o) |-> (is_read(kind_r) && state_r != ST_T1 && !data_lines_oe))
    else $error("read strobe outside read phase");
  chk_pe_code_bus: assert property (@(posedge clk) disable iff (srst) // [R15]
    (state_r == ST_T1 && kind_r == K_PE_FOUR) |->
      (!address_lines_oe && data_lines_oe && data_lines_o == PE_CODE_FOUR))
    else $error("code four cycle wrong");
  chk_pe_one_bus: assert property (@(posedge clk) disable iff (srst) // [R13]
    (state_r == ST_T1 && kind_r == K_PE_ONE) |->
      (address_lines_oe && data_lines_o == PE_CODE_ONE && port_cycle_pulse))
    else $error("code one cycle wrong");
  chk_strobe_ends: assert property (@(posedge clk) disable iff (srst) // [R19]
    (ce && state_r == ST_T3) |=> !port_cycle_pulse)
    else $error("port strobe stuck after cycle");
  chk_hold_redrive: assert property (@(posedge clk) disable iff (srst) // [R20]
    ($fell(hold_grant) && !halt) |-> ##[0:HOLD_CHK] read_strobe_n_oe)
    else $error("bus not driven again after hold");
endmodule : rbp_bus_port
`default_nettype wire

/* hw/rbp_pkg.sv */
// How it works
// [R1] far_memory_flag_n goes low while a memory cycle addresses 4096 to 65407.
// [R2] memory cycles drive address lines only at 0 to 4095; io and code one/two cycles always drive them.
// [R3] data lines are an 8-bit active-high bidirectional bus with enable.
// [R4] level_irq_input requests an interrupt for as long as it is high.
// [R5] rising edge of rising_irq_input pends an interrupt only when interrupts enabled.
// [R6] third interrupt edge polarity follows edge_polarity_select: 1 rising, 0 falling.
// [R7] wait_n sampled at end of T2; stretch_state holds while wait_n low.
// [R8] opcode_fetch_flag is high throughout opcode fetch cycles only.
// [R9] write strobe low only with valid write data; floats in halt, hold, reset.
// [R10] read strobe gates external data; floats in halt, hold and reset.
// [R11] serial input shifts in MSB first on serial clock rising edges.
// [R12] serial output shifts out MSB first on serial clock falling edges.
// [R13] port_emulation_code_one puts B,C on address lines and 01h on data.
// [R14] port_emulation_code_two puts B,C on address lines and 02h on data.
// [R15] port_emulation_code_four floats address lines and drives 04h on data.
// [R16] port_cycle_pulse is high while any port-emulation cycle runs.
// [R17] the clock is supplied from outside on clock_input_pin (clk here).
// [R18] each bidir_port line is an input or output on its own.
// [R19] port_cycle_pulse drops when that cycle ends; never high in other cycles.
// [R20] buses float when hold_grant rises and are driven again after it falls.
package rbp_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam logic [15:0] PROG_LAST = 16'h0fff;
  localparam logic [15:0] FAR_FIRST = 16'h1000;
  localparam logic [15:0] FAR_LAST = 16'hff7f;
  localparam logic [7:0] PE_CODE_ONE = 8'h01;
  localparam logic [7:0] PE_CODE_TWO = 8'h02;
  localparam logic [7:0] PE_CODE_FOUR = 8'h04;
  localparam logic [3:0] SER_LAST = 4'h8;
  localparam logic [3:0] SER_ZERO = 4'h0;
  localparam logic [3:0] SER_ONE = 4'h1;
  localparam int CLK_NS = 50;
  localparam int HOLD_REDRIVE_NS = 350;
  // longest time: round down, at least one cycle
  localparam int HOLD_REDRIVE_CYC = (HOLD_REDRIVE_NS / CLK_NS) < 1 ? 1 :
                                    (HOLD_REDRIVE_NS / CLK_NS);

  typedef enum logic [2:0] {
    K_FETCH = 3'h0,
    K_MEM_RD = 3'h1,
    K_MEM_WR = 3'h2,
    K_IO_RD = 3'h3,
    K_IO_WR = 3'h4,
    K_PE_ONE = 3'h5,
    K_PE_TWO = 3'h6,
    K_PE_FOUR = 3'h7
  } rbp_kind_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_T1 = 3'h1,
    ST_T2 = 3'h2,
    ST_TW = 3'h3,
    ST_T3 = 3'h4
  } rbp_state_e;
endpackage : rbp_pkg

/* hw/rbp_ser_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface rbp_ser_if;
  logic sck_rise;
  logic sck_fall;
  logic serial_in;
  logic load;
  logic [7:0] load_data;
  logic serial_out;
  logic [7:0] rx_data;
  logic done;
  modport ctl (output sck_rise, output sck_fall, output serial_in, output load,
               output load_data, input serial_out, input rx_data, input done);
  modport shf (input sck_rise, input sck_fall, input serial_in, input load,
               input load_data, output serial_out, output rx_data, output done);
endinterface : rbp_ser_if
`default_nettype wire

/* hw/rbp_serial.sv */
`timescale 1ns/1ps
`default_nettype none
module rbp_serial
  import rbp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // link to the bus port
  rbp_ser_if.shf sif
);
  logic [7:0] shift_r, shift_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic so_r, so_nxt;
  logic done_r, done_nxt;

  always_comb begin
    shift_nxt = shift_r;
    cnt_nxt = cnt_r;
    so_nxt = so_r;
    done_nxt = 1'b0;
    if (sif.load) begin
      shift_nxt = sif.load_data;
      cnt_nxt = SER_ZERO;
    end else begin
      // [R12] msb out on falling edge
      if (sif.sck_fall) begin
        so_nxt = shift_r[7];
      end
      // [R11] msb first in on rising edge
      if (sif.sck_rise) begin
        shift_nxt = {shift_r[6:0], sif.serial_in};
        cnt_nxt = (cnt_r == SER_LAST - SER_ONE) ? SER_ZERO : cnt_r + SER_ONE;
        done_nxt = (cnt_r == SER_LAST - SER_ONE);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      shift_r <= 8'h00;
      cnt_r <= SER_ZERO;
      so_r <= 1'b1;
      done_r <= 1'b0;
    end else if (ce) begin
      shift_r <= shift_nxt;
      cnt_r <= cnt_nxt;
      so_r <= so_nxt;
      done_r <= done_nxt;
    end
  end

  assign sif.serial_out = so_r;
  assign sif.rx_data = shift_r;
  assign sif.done = done_r;

  chk_ser_shift_in: assert property (@(posedge clk) disable iff (srst) // [R11]
    (ce && sif.sck_rise && !sif.load) |=> (shift_r[0] == $past(sif.serial_in)
      && shift_r[7:1] == $past(shift_r[6:0])))
    else $error("serial input not shifted msb first");
  chk_ser_shift_out: assert property (@(posedge clk) disable iff (srst) // [R12]
    (ce && sif.sck_fall && !sif.load) |=> so_r == $past(shift_r[7]))
    else $error("serial output not msb on falling edge");
endmodule : rbp_serial
`default_nettype wire
